/* core/xfer_instr_exec.v */
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
`include "xfer_instr_defs.vh"

module xfer_instr_exec #(
	parameter ACC_W  = 4,
	parameter PRE_W  = 8,
	parameter ADDR_W = 4
) (
	input  wire              mclk_i,
	input  wire              srst_i,
	input  wire              instr_valid_i,
	input  wire [9:0]        instr_i,
	input  wire [ACC_W-1:0]  acc_i,
	input  wire [ACC_W-1:0]  breg_i,
	input  wire              alu_carry_we_i,
	input  wire              alu_carry_i,
	input  wire              alu_skip_i,
	input  wire              prescaler_tick_i,
	input  wire [ADDR_W-1:0] addr_i,
	input  wire [PRE_W-1:0]  wdata_i,
	input  wire              we_i,
	input  wire              re_i,
	output reg  [PRE_W-1:0]  rdata_o,
	output reg  [ACC_W-1:0]  clock_ctrl_o,
	output reg  [ACC_W-1:0]  timer_ctrl_o,
	output reg  [PRE_W-1:0]  prescaler_reload_o,
	output reg  [PRE_W-1:0]  prescaler_count_o,
	output reg  [ACC_W-1:0]  pullup0_o,
	output reg               carry_flag_o,
	output reg               skip_o,
	output reg               exec_done_o
);

	reg  [ACC_W-1:0] clock_control_reg;
	reg  [ACC_W-1:0] timer_control_reg;
	reg  [PRE_W-1:0] prescaler_reload_reg;
	reg  [PRE_W-1:0] prescaler_counter;
	reg  [ACC_W-1:0] pullup_control_reg_zero;
	reg              carry_flag;
	reg  [3:0]       last_op;
	reg  [3:0]       exec_count;

	reg  [PRE_W-1:0] next_rdata;
	reg  [PRE_W-1:0] next_counter;

	wire             load_clock_ctrl_instr;
	wire             load_timer_ctrl_bit_instr;
	wire             load_prescaler_pair_instr;
	wire             load_pullup0_instr;
	wire             any_xfer;
	wire [PRE_W-1:0] pair_value;

	wire             wr_clock;
	wire             wr_timer;
	wire             wr_reload;
	wire             wr_count;
	wire             wr_pullup;
	wire             wr_carry;

	// decode: each transfer is a single-word instruction
	assign load_clock_ctrl_instr     = instr_valid_i &&
		(instr_i == `OPC_LOAD_CLOCK_CTRL);
	assign load_timer_ctrl_bit_instr = instr_valid_i &&
		(instr_i == `OPC_LOAD_TIMER_BIT);
	assign load_prescaler_pair_instr = instr_valid_i &&
		(instr_i == `OPC_LOAD_PRESCALER);
	assign load_pullup0_instr        = instr_valid_i &&
		(instr_i == `OPC_LOAD_PULLUP0);

	assign any_xfer = load_clock_ctrl_instr |
		load_timer_ctrl_bit_instr |
		load_prescaler_pair_instr |
		load_pullup0_instr;

	// second register forms the high nibble, accumulator the low one
	assign pair_value = {breg_i, acc_i};

	assign wr_clock  = we_i && (addr_i == `ADDR_CLOCK_CTRL);
	assign wr_timer  = we_i && (addr_i == `ADDR_TIMER_CTRL);
	assign wr_reload = we_i && (addr_i == `ADDR_PRESC_RELOAD);
	assign wr_count  = we_i && (addr_i == `ADDR_PRESC_COUNT);
	assign wr_pullup = we_i && (addr_i == `ADDR_PULLUP0);
	assign wr_carry  = we_i && (addr_i == `ADDR_CARRY);

	// the instruction wins over a software write in the same cycle,
	// so the core never sees its own transfer undone
	always @(posedge mclk_i) begin
		if (srst_i) begin
			clock_control_reg <= `RST_CLOCK_CTRL;
		end else if (load_clock_ctrl_instr) begin
			clock_control_reg <= acc_i;
		end else if (wr_clock) begin
			clock_control_reg <= wdata_i[ACC_W-1:0];
		end
	end

	// only bit 0 follows the instruction; upper bits keep their value
	always @(posedge mclk_i) begin
		if (srst_i) begin
			timer_control_reg <= `RST_TIMER_CTRL;
		end else if (load_timer_ctrl_bit_instr) begin
			timer_control_reg[`TIMER_BIT_POS] <=
				acc_i[`TIMER_BIT_POS];
		end else if (wr_timer) begin
			timer_control_reg <= wdata_i[ACC_W-1:0];
		end
	end

	always @(posedge mclk_i) begin
		if (srst_i) begin
			prescaler_reload_reg <= `RST_PRESC_RELOAD;
		end else if (load_prescaler_pair_instr) begin
			prescaler_reload_reg <= pair_value;
		end else if (wr_reload) begin
			prescaler_reload_reg <= wdata_i;
		end
	end

	// counter: instruction load, then software write, then tick;
	// a tick at zero reloads, otherwise it counts down
	always @* begin
		next_counter = prescaler_counter;
		if (load_prescaler_pair_instr) begin
			next_counter = pair_value;
		end else if (wr_count) begin
			next_counter = wdata_i;
		end else if (prescaler_tick_i) begin
			if (prescaler_counter == {PRE_W{1'b0}}) begin
				next_counter = prescaler_reload_reg;
			end else begin
				next_counter = prescaler_counter - 1'b1;
			end
		end
	end

	always @(posedge mclk_i) begin
		if (srst_i) begin
			prescaler_counter <= `RST_PRESC_COUNT;
		end else begin
			prescaler_counter <= next_counter;
		end
	end

	always @(posedge mclk_i) begin
		if (srst_i) begin
			pullup_control_reg_zero <= `RST_PULLUP0;
		end else if (load_pullup0_instr) begin
			pullup_control_reg_zero <= acc_i;
		end else if (wr_pullup) begin
			pullup_control_reg_zero <= wdata_i[ACC_W-1:0];
		end
	end

	// carry: the alu may not touch it while a transfer executes
	always @(posedge mclk_i) begin
		if (srst_i) begin
			carry_flag <= `RST_CARRY;
		end else if (any_xfer) begin
			carry_flag <= carry_flag;
		end else if (alu_carry_we_i) begin
			carry_flag <= alu_carry_i;
		end else if (wr_carry) begin
			carry_flag <= wdata_i[`CARRY_BIT_POS];
		end
	end

	// status: which transfer ran last and how many have run
	always @(posedge mclk_i) begin
		if (srst_i) begin
			last_op    <= `RST_LAST_OP;
			exec_count <= `RST_EXEC_COUNT;
		end else if (any_xfer) begin
			exec_count <= exec_count + 4'h1;
			if (load_clock_ctrl_instr) begin
				last_op <= `LAST_CLOCK;
			end else if (load_timer_ctrl_bit_instr) begin
				last_op <= `LAST_TIMER;
			end else if (load_prescaler_pair_instr) begin
				last_op <= `LAST_PRESC;
			end else begin
				last_op <= `LAST_PULLUP;
			end
		end
	end

	// outputs copy the registers one edge later: a cycle of latency
	// traded for outputs that come straight from flops
	always @(posedge mclk_i) begin
		if (srst_i) begin
			clock_ctrl_o       <= `RST_CLOCK_CTRL;
			timer_ctrl_o       <= `RST_TIMER_CTRL;
			prescaler_reload_o <= `RST_PRESC_RELOAD;
			prescaler_count_o  <= `RST_PRESC_COUNT;
			pullup0_o          <= `RST_PULLUP0;
			carry_flag_o       <= `RST_CARRY;
		end else begin
			clock_ctrl_o       <= clock_control_reg;
			timer_ctrl_o       <= timer_control_reg;
			prescaler_reload_o <= prescaler_reload_reg;
			prescaler_count_o  <= prescaler_counter;
			pullup0_o          <= pullup_control_reg_zero;
			carry_flag_o       <= carry_flag;
		end
	end

	// skip request and completion pulse for the sequencer
	always @(posedge mclk_i) begin
		if (srst_i) begin
			skip_o      <= 1'b0;
			exec_done_o <= 1'b0;
		end else begin
			skip_o      <= alu_skip_i & ~any_xfer;
			exec_done_o <= any_xfer;
		end
	end

	// read mux; unmapped addresses read zero
	always @* begin
		next_rdata = {PRE_W{1'b0}};
		case (addr_i)
		`ADDR_CLOCK_CTRL: begin
			next_rdata[ACC_W-1:0] = clock_control_reg;
		end
		`ADDR_TIMER_CTRL: begin
			next_rdata[ACC_W-1:0] = timer_control_reg;
		end
		`ADDR_PRESC_RELOAD: begin
			next_rdata = prescaler_reload_reg;
		end
		`ADDR_PRESC_COUNT: begin
			next_rdata = prescaler_counter;
		end
		`ADDR_PULLUP0: begin
			next_rdata[ACC_W-1:0] = pullup_control_reg_zero;
		end
		`ADDR_CARRY: begin
			next_rdata[`CARRY_BIT_POS] = carry_flag;
		end
		`ADDR_LAST_OP: begin
			next_rdata[3:0] = last_op;
		end
		`ADDR_EXEC_COUNT: begin
			next_rdata[3:0] = exec_count;
		end
		default: begin
			next_rdata = {PRE_W{1'b0}};
		end
		endcase
	end

	// data stands only in the cycle after the read strobe
	always @(posedge mclk_i) begin
		if (srst_i) begin
			rdata_o <= {PRE_W{1'b0}};
		end else if (re_i) begin
			rdata_o <= next_rdata;
		end else begin
			rdata_o <= {PRE_W{1'b0}};
		end
	end

endmodule

/* common/xfer_instr_defs.vh */
`ifndef XFER_INSTR_DEFS_VH
`define XFER_INSTR_DEFS_VH

// instruction codes, 10-bit words
`define OPC_LOAD_CLOCK_CTRL   10'h2B6
`define OPC_LOAD_TIMER_BIT    10'h2AA
`define OPC_LOAD_PRESCALER    10'h235
`define OPC_LOAD_PULLUP0      10'h22D

// register word addresses
`define ADDR_CLOCK_CTRL       4'h0
`define ADDR_TIMER_CTRL       4'h1
`define ADDR_PRESC_RELOAD     4'h2
`define ADDR_PRESC_COUNT      4'h3
`define ADDR_PULLUP0          4'h4
`define ADDR_CARRY            4'h5
`define ADDR_LAST_OP          4'h6
`define ADDR_EXEC_COUNT       4'h7

// field positions
`define TIMER_BIT_POS         0
`define CARRY_BIT_POS         0
`define PRESC_HI_MSB          7
`define PRESC_HI_LSB          4
`define PRESC_LO_MSB          3
`define PRESC_LO_LSB          0

// reset values
`define RST_CLOCK_CTRL        4'h0
`define RST_TIMER_CTRL        4'h0
`define RST_PRESC_RELOAD      8'h00
`define RST_PRESC_COUNT       8'h00
`define RST_PULLUP0           4'h0
`define RST_CARRY             1'b0
`define RST_LAST_OP           4'h0
`define RST_EXEC_COUNT        4'h0

// one-hot codes for the last transfer executed
`define LAST_CLOCK            4'h1
`define LAST_TIMER            4'h2
`define LAST_PRESC            4'h4
`define LAST_PULLUP           4'h8

`endif

/* verification/xfer_instr_monitor.sv */
`timescale 1ns/100ps
`include "xfer_instr_defs.vh"

module xfer_instr_monitor (
	input wire       mclk_i,
	input wire       srst_i,
	input wire       instr_valid_i,
	input wire [9:0] instr_i,
	input wire [3:0] acc_i,
	input wire [3:0] breg_i,
	input wire       alu_skip_i,
	input wire [3:0] clock_ctrl_o,
	input wire [3:0] timer_ctrl_o,
	input wire [7:0] prescaler_reload_o,
	input wire [7:0] prescaler_count_o,
	input wire [3:0] pullup0_o,
	input wire       carry_flag_o,
	input wire       skip_o,
	input wire       exec_done_o
);
	wire v = instr_valid_i;
	wire xfer = v && (instr_i == `OPC_LOAD_CLOCK_CTRL
		|| instr_i == `OPC_LOAD_TIMER_BIT
		|| instr_i == `OPC_LOAD_PRESCALER || instr_i == `OPC_LOAD_PULLUP0);

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	// outputs lag the internal copy by one edge, hence two cycles
	chk_clock_load: assert property (v && instr_i == `OPC_LOAD_CLOCK_CTRL
		|-> ##2 clock_ctrl_o == $past(acc_i, 2)) else $error("clock load bad");
	chk_timer_bit: assert property (v && instr_i == `OPC_LOAD_TIMER_BIT
		|-> ##2 timer_ctrl_o[0] == $past(acc_i[0], 2)) else $error("timer bad");
	chk_presc_pair: assert property (v && instr_i == `OPC_LOAD_PRESCALER
		|-> ##2 prescaler_reload_o == $past({breg_i, acc_i}, 2))
		else $error("prescaler load bad");
	chk_pullup_load: assert property (v && instr_i == `OPC_LOAD_PULLUP0
		|-> ##2 pullup0_o == $past(acc_i, 2)) else $error("pull-up load bad");
	chk_carry_frozen: assert property (xfer |=> ##1 $stable(carry_flag_o))
		else $error("carry changed by transfer");
	chk_skip_blocked: assert property (xfer |=> !skip_o)
		else $error("transfer caused skip");
	chk_presc_count: assert property (v && instr_i == `OPC_LOAD_PRESCALER
		|-> ##2 prescaler_count_o == $past({breg_i, acc_i}, 2))
		else $error("prescaler counter load bad");
	chk_done_pulse: assert property (xfer |=> exec_done_o)
		else $error("no completion pulse");
	chk_done_idle: assert property (!xfer |=> !exec_done_o)
		else $error("completion pulse without transfer");

	cover property (xfer && alu_skip_i);
	cover property (xfer ##1 xfer);
	cover property (v && !xfer && alu_skip_i);
endmodule

bind xfer_instr_exec xfer_instr_monitor mon (.mclk_i, .srst_i, .instr_valid_i,
	.instr_i, .acc_i, .breg_i, .alu_skip_i, .clock_ctrl_o, .timer_ctrl_o,
	.prescaler_reload_o, .prescaler_count_o, .pullup0_o, .carry_flag_o,
	.skip_o, .exec_done_o);

/* verification/tb_top.sv */
`timescale 1ns/100ps
`include "xfer_instr_defs.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
	$display("MISMATCH %0t got %h exp %h", $time, g, e); end end

module tb_top;
	reg        mclk_i = 0;
	reg        srst_i = 1;
	reg        instr_valid_i = 0;
	reg        alu_carry_we_i = 0;
	reg        alu_skip_i = 0;
	reg        prescaler_tick_i = 0;
	reg        we_i = 0;
	reg        re_i = 0;
	reg  [9:0] instr_i = 0;
	reg  [3:0] acc_i = 0;
	reg  [3:0] breg_i = 0;
	reg  [3:0] addr_i = 0;
	reg  [7:0] wdata_i = 0;
	wire [7:0] rdata_o;
	wire [3:0] pullup0_o;
	wire       skip_o;
	int        n_errors = 0;
	int        cmp_count = 0;
	int        cyc = 0;
	logic [9:0] ops [4] = '{`OPC_LOAD_CLOCK_CTRL, `OPC_LOAD_TIMER_BIT,
		`OPC_LOAD_PRESCALER, `OPC_LOAD_PULLUP0};

	xfer_instr_exec dut (.mclk_i(mclk_i), .srst_i(srst_i),
		.instr_valid_i(instr_valid_i), .instr_i(instr_i), .acc_i(acc_i),
		.breg_i(breg_i), .alu_carry_we_i(alu_carry_we_i), .alu_carry_i(1'b0),
		.alu_skip_i(alu_skip_i), .prescaler_tick_i(prescaler_tick_i),
		.addr_i(addr_i),
		.wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
		.clock_ctrl_o(), .timer_ctrl_o(), .prescaler_reload_o(),
		.prescaler_count_o(), .pullup0_o(pullup0_o), .carry_flag_o(),
		.skip_o(skip_o), .exec_done_o());

	initial forever #50 mclk_i = ~mclk_i;

	// the whole sequence needs well under 300 cycles
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_errors++;
			conclude;
		end
	end

	task conclude;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task wr(input [3:0] a, input [7:0] d);
		@(posedge mclk_i);
		we_i <= 1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		we_i <= 0;
	endtask

	task tick;
		@(posedge mclk_i);
		prescaler_tick_i <= 1;
		@(posedge mclk_i);
		prescaler_tick_i <= 0;
	endtask

	task rd(input [3:0] a, input [7:0] e);
		@(posedge mclk_i);
		re_i <= 1;
		addr_i <= a;
		@(posedge mclk_i);
		re_i <= 0;
		#1 `CHK(rdata_o, e)
	endtask

	// cw asks the alu to clear carry in the same cycle
	task ex(input [9:0] op, input [3:0] b, a, input cw, sk, es);
		@(posedge mclk_i);
		instr_valid_i <= 1;
		instr_i <= op;
		breg_i <= b;
		acc_i <= a;
		alu_carry_we_i <= cw;
		alu_skip_i <= sk;
		@(posedge mclk_i);
		instr_valid_i <= 0;
		alu_carry_we_i <= 0;
		alu_skip_i <= 0;
		#1 `CHK(skip_o, es)
	endtask

	initial begin
		repeat (4) @(posedge mclk_i);
		srst_i <= 0;
		for (int i = 0; i < 10; i++)
			rd(i[3:0], 8'h00);
		ex(`OPC_LOAD_CLOCK_CTRL, 4'h3, 4'hF, 0, 0, 0);
		rd(`ADDR_CLOCK_CTRL, 8'h0F);
		wr(`ADDR_TIMER_CTRL, 8'h0E);
		ex(`OPC_LOAD_TIMER_BIT, 4'h0, 4'h5, 0, 0, 0);
		rd(`ADDR_TIMER_CTRL, 8'h0F);
		ex(`OPC_LOAD_TIMER_BIT, 4'h0, 4'hE, 0, 0, 0);
		rd(`ADDR_TIMER_CTRL, 8'h0E);
		// loads one idle cycle apart must not disturb each other
		ex(`OPC_LOAD_PRESCALER, 4'hA, 4'h5, 0, 0, 0);
		ex(`OPC_LOAD_PULLUP0, 4'h0, 4'h9, 0, 0, 0);
		rd(`ADDR_PRESC_RELOAD, 8'hA5);
		rd(`ADDR_PRESC_COUNT, 8'hA5);
		rd(`ADDR_PULLUP0, 8'h09);
		`CHK(pullup0_o, 4'h9)
		// count down one tick, then reload once the counter sits at zero
		tick;
		rd(`ADDR_PRESC_COUNT, 8'hA4);
		wr(`ADDR_PRESC_COUNT, 8'h00);
		tick;
		rd(`ADDR_PRESC_COUNT, 8'hA5);
		// two transfers on consecutive edges
		@(posedge mclk_i);
		instr_valid_i <= 1;
		instr_i <= `OPC_LOAD_CLOCK_CTRL;
		acc_i <= 4'h6;
		@(posedge mclk_i);
		instr_i <= `OPC_LOAD_PULLUP0;
		acc_i <= 4'h3;
		@(posedge mclk_i);
		instr_valid_i <= 0;
		rd(`ADDR_CLOCK_CTRL, 8'h06);
		rd(`ADDR_PULLUP0, 8'h03);
		wr(`ADDR_CARRY, 8'h01);
		for (int i = 0; i < 4; i++) begin
			ex(ops[i], 4'h1, 4'h2, 1, 1, 0);
			rd(`ADDR_CARRY, 8'h01);
		end
		rd(`ADDR_CLOCK_CTRL, 8'h02);
		rd(`ADDR_TIMER_CTRL, 8'h0E);
		rd(`ADDR_PRESC_RELOAD, 8'h12);
		rd(`ADDR_LAST_OP, 8'h08);
		rd(`ADDR_EXEC_COUNT, 8'h0B);
		// an unknown code is no transfer: skip and carry write go through
		ex(10'h3FF, 4'h0, 4'h7, 1, 1, 1);
		rd(`ADDR_CARRY, 8'h00);
		rd(`ADDR_CLOCK_CTRL, 8'h02);
		rd(`ADDR_EXEC_COUNT, 8'h0B);
		conclude;
	end
endmodule
